// file: verilog/sptc_top.v
// Purpose: Stepper pulse-train control with accel, run and brake phases
// Assumes: Single 200 MHz clock, synchronous active-high reset
// Notes:   Frequencies in Hz, ramp rates in mHz per step
// Operation
// - Start and jog act only while enabled
// - Enable falling edge fully resets state
// - Disable stops pulses abruptly, no ramp
// - Start rising edge launches normal job
// - Job-active high while job runs
// - Start launches only with brake low
// - Accel, run, brake phases in order
// - Start edges ignored during running job
// - Brake edge in accel or run aborts into braking ramp
// - Brake acts only while jog low
// - Job-active stays until braking completes
// - Start ignored during braking phase
// - Short jog moves jog step count
// - Long jog ramps to jog frequency
// - Brake ignored while jog active
// - Total count spans all three phases
// - Pulses square, half-period on time
// - Ramp counts from frequency span and rate
`timescale 1ns/1ps
`default_nettype none
`include "sptc_map.vh"
module sptc_top #(
    parameter [31:0] JOG_HOLD_CYCLES = `SPTC_JOG_HOLD_MS * `SPTC_CLK_KHZ
) (
    // Clock and reset
    input  wire        mclk,
    input  wire        rst,
    // AXI4-Lite write
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Motor stage
    output reg         pulse_out,
    output reg         job_active_output
);

// ============================================================
// States
localparam [5:0] ST_IDLE  = 6'b000001;
localparam [5:0] ST_CALC  = 6'b000010;
localparam [5:0] ST_ACCEL = 6'b000100;
localparam [5:0] ST_RUN   = 6'b001000;
localparam [5:0] ST_BRAKE = 6'b010000;
localparam [5:0] ST_JOG   = 6'b100000;

// ============================================================
// Registers
reg  [3:0]  ctrl_q;
reg  [31:0] total_pulse_count;
reg  [31:0] freq_cfg_q;
reg  [31:0] rate_cfg_q;
reg  [31:0] jog_cfg_q;
reg  [3:0]  ctrl_prev_q;
reg  [5:0]  state_q;
reg         abort_q;
reg         manual_q;
reg  [31:0] cur_mhz_q;
reg  [39:0] acc_q;
reg  [31:0] cnt_q;
reg  [31:0] brake_n_q;
reg  [31:0] rem_q;
reg  [31:0] quo_q;
reg  [5:0]  div_cnt_q;
reg  [31:0] jog_tmr_q;
reg  [7:0]  aw_addr_q;
reg  [31:0] w_data_q;
reg  [3:0]  w_strb_q;
reg         aw_got_q;
reg         w_got_q;

wire [15:0] start_frequency     = freq_cfg_q[15:0];
wire [15:0] operating_frequency = freq_cfg_q[31:16];
wire [15:0] accel_rate_per_step = rate_cfg_q[15:0];
wire [15:0] brake_rate_per_step = rate_cfg_q[31:16];
wire [15:0] jog_step_count      = jog_cfg_q[15:0];
wire [15:0] jog_frequency       = jog_cfg_q[31:16];

wire enable      = ctrl_q[`SPTC_CTRL_EN];
wire jog_input   = ctrl_q[`SPTC_CTRL_JOG];
wire en_fall     = ctrl_prev_q[`SPTC_CTRL_EN] & ~enable;
wire start_rise  = ctrl_q[`SPTC_CTRL_START] & ~ctrl_prev_q[`SPTC_CTRL_START];
wire brake_rise  = ctrl_q[`SPTC_CTRL_BRAKE] & ~ctrl_prev_q[`SPTC_CTRL_BRAKE];
wire jog_rise    = jog_input & ~ctrl_prev_q[`SPTC_CTRL_JOG];
wire brake_input = ctrl_q[`SPTC_CTRL_BRAKE];

// ============================================================
// Frequencies in mHz
wire [31:0] fs_mhz  = start_frequency * `SPTC_MHZ_PER_HZ;
wire [31:0] fo_mhz  = operating_frequency * `SPTC_MHZ_PER_HZ;
wire [31:0] pf_mhz  = jog_frequency * `SPTC_MHZ_PER_HZ;
wire [31:0] up_mhz  = cur_mhz_q + {16'h0000, accel_rate_per_step};
wire [31:0] dn_mhz  = cur_mhz_q - {16'h0000, brake_rate_per_step};
wire        dn_low  = (cur_mhz_q < fs_mhz + {16'h0000, brake_rate_per_step});
wire [31:0] cnt_d   = cnt_q + 32'h0000_0001;
wire [31:0] left_d  = total_pulse_count - cnt_d;

// ============================================================
// Pulse engine: accumulator toggles every half period
wire        jog_pulsing = manual_q | (cnt_q < {16'h0000, jog_step_count});
wire        pulsing = (state_q == ST_ACCEL) | (state_q == ST_RUN) | (state_q == ST_BRAKE)
                    | ((state_q == ST_JOG) & jog_pulsing);
wire [39:0] acc_sum = acc_q + {8'h00, cur_mhz_q};
wire        toggle  = pulsing & (acc_sum >= `SPTC_HALF_PERIOD);
wire        step_done = toggle & pulse_out;

// Restoring divider step
wire [32:0] div_trial = {rem_q, quo_q[31]} - {17'h0_0000, brake_rate_per_step};

// ============================================================
// Control
always @(posedge mclk) begin
    if (rst || en_fall || !enable) begin
        state_q           <= ST_IDLE;
        abort_q           <= 1'b0;
        manual_q          <= 1'b0;
        cur_mhz_q         <= `SPTC_RST_WORD;
        acc_q             <= 40'h00_0000_0000;
        cnt_q             <= `SPTC_RST_WORD;
        brake_n_q         <= `SPTC_RST_WORD;
        rem_q             <= `SPTC_RST_WORD;
        quo_q             <= `SPTC_RST_WORD;
        div_cnt_q         <= 6'h00;
        jog_tmr_q         <= `SPTC_RST_WORD;
        pulse_out         <= 1'b0;
        job_active_output <= 1'b0;
    end else begin
        // equal halves from one accumulator threshold
        if (!pulsing) begin
            acc_q     <= 40'h00_0000_0000;
            pulse_out <= 1'b0;
        end else if (toggle) begin
            acc_q     <= acc_sum - `SPTC_HALF_PERIOD;
            pulse_out <= ~pulse_out;
        end else begin
            acc_q <= acc_sum;
        end
        if (step_done)
            cnt_q <= cnt_d;
        case (state_q)
            ST_IDLE: begin
                if (jog_rise) begin
                    state_q           <= ST_JOG;
                    manual_q          <= 1'b0;
                    jog_tmr_q         <= `SPTC_RST_WORD;
                    cnt_q             <= `SPTC_RST_WORD;
                    cur_mhz_q         <= (fs_mhz < pf_mhz) ? fs_mhz : pf_mhz;
                    job_active_output <= 1'b1;
                end else if (start_rise && !brake_input && total_pulse_count != 32'h0000_0000) begin
                    state_q           <= ST_CALC;
                    abort_q           <= 1'b0;
                    cnt_q             <= `SPTC_RST_WORD;
                    cur_mhz_q         <= fs_mhz;
                    rem_q             <= `SPTC_RST_WORD;
                    quo_q             <= (fo_mhz > fs_mhz) ? fo_mhz - fs_mhz : `SPTC_RST_WORD;
                    div_cnt_q         <= `SPTC_DIV_STEPS;
                    job_active_output <= 1'b1;
                end
            end
            ST_CALC: begin
                // Serial divide keeps the area small; costs 33 cycles in ST_CALC before the first pulse
                if (div_cnt_q != 6'h00) begin
                    div_cnt_q <= div_cnt_q - 6'h01;
                    if (!div_trial[32]) begin
                        rem_q <= div_trial[31:0];
                        quo_q <= {quo_q[30:0], 1'b1};
                    end else begin
                        rem_q <= {rem_q[30:0], quo_q[31]};
                        quo_q <= {quo_q[30:0], 1'b0};
                    end
                end else begin
                    brake_n_q <= (brake_rate_per_step == 16'h0000) ? `SPTC_RST_WORD : quo_q;
                    state_q   <= (fo_mhz > fs_mhz) ? ST_ACCEL : ST_RUN;
                    if (fo_mhz <= fs_mhz)
                        cur_mhz_q <= fo_mhz;
                end
            end
            ST_ACCEL, ST_RUN: begin
                if (brake_rise && !jog_input) begin
                    state_q <= ST_BRAKE;
                    abort_q <= 1'b1;
                end else if (step_done) begin
                    if (state_q == ST_ACCEL)
                        cur_mhz_q <= (up_mhz >= fo_mhz) ? fo_mhz : up_mhz;
                    if (left_d == 32'h0000_0000) begin
                        state_q           <= ST_IDLE;
                        job_active_output <= 1'b0;
                    end else if (left_d <= brake_n_q) begin
                        state_q   <= ST_BRAKE;
                        cur_mhz_q <= dn_low ? fs_mhz : dn_mhz;
                    end else if (state_q == ST_ACCEL && up_mhz >= fo_mhz)
                        state_q <= ST_RUN;
                end
            end
            ST_BRAKE: begin
                // Start edges are not looked at here
                if (step_done) begin
                    cur_mhz_q <= dn_low ? fs_mhz : dn_mhz;
                    if (left_d == 32'h0000_0000 || (abort_q && dn_low)) begin
                        state_q           <= ST_IDLE;
                        abort_q           <= 1'b0;
                        job_active_output <= 1'b0;
                    end
                end
            end
            ST_JOG: begin
                if (jog_input && !manual_q) begin
                    if (jog_tmr_q >= JOG_HOLD_CYCLES)
                        manual_q <= 1'b1;
                    else
                        jog_tmr_q <= jog_tmr_q + 32'h0000_0001;
                end
                if (step_done)
                    cur_mhz_q <= (up_mhz >= pf_mhz) ? pf_mhz : up_mhz;
                if (!jog_input && (manual_q || !jog_pulsing)) begin
                    state_q           <= ST_IDLE;
                    manual_q          <= 1'b0;
                    pulse_out         <= 1'b0;
                    job_active_output <= 1'b0;
                end
            end
            default: state_q <= ST_IDLE;
        endcase
    end
end

// ============================================================
// Edge history runs regardless, so a falling enable is seen once
always @(posedge mclk) begin
    if (rst)
        ctrl_prev_q <= `SPTC_RST_CTRL;
    else
        ctrl_prev_q <= ctrl_q;
end

// ============================================================
// AXI4-Lite write channel
function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  st;
    integer i;
    begin
        merge = old;
        for (i = 0; i < 4; i = i + 1)
            if (st[i])
                merge[8*i +: 8] = wd[8*i +: 8];
    end
endfunction

wire aw_hs  = s_axi_awvalid & s_axi_awready;
wire w_hs   = s_axi_wvalid & s_axi_wready;
wire aw_now = aw_got_q | aw_hs;
wire w_now  = w_got_q | w_hs;
wire [7:0]  wr_addr = aw_got_q ? aw_addr_q : s_axi_awaddr;
wire [31:0] wr_data = w_got_q ? w_data_q : s_axi_wdata;
wire [3:0]  wr_strb = w_got_q ? w_strb_q : s_axi_wstrb;
wire        wr_go   = aw_now & w_now & ~s_axi_bvalid;
wire        wr_map  = (wr_addr <= `SPTC_OFS_JOG) && (wr_addr[1:0] == 2'b00);
wire [31:0] ctrl_merged = merge({28'h000_0000, ctrl_q}, wr_data, wr_strb);

always @(posedge mclk) begin
    if (rst) begin
        s_axi_awready     <= 1'b1;
        s_axi_wready      <= 1'b1;
        s_axi_bvalid      <= 1'b0;
        s_axi_bresp       <= `SPTC_RESP_OKAY;
        aw_got_q          <= 1'b0;
        w_got_q           <= 1'b0;
        aw_addr_q         <= 8'h00;
        w_data_q          <= `SPTC_RST_WORD;
        w_strb_q          <= 4'h0;
        ctrl_q            <= `SPTC_RST_CTRL;
        total_pulse_count <= `SPTC_RST_WORD;
        freq_cfg_q        <= `SPTC_RST_WORD;
        rate_cfg_q        <= `SPTC_RST_WORD;
        jog_cfg_q         <= `SPTC_RST_WORD;
    end else begin
        if (aw_hs) begin
            aw_got_q      <= 1'b1;
            aw_addr_q     <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end
        if (w_hs) begin
            w_got_q      <= 1'b1;
            w_data_q     <= s_axi_wdata;
            w_strb_q     <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end
        if (wr_go) begin
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_map ? `SPTC_RESP_OKAY : `SPTC_RESP_SLVERR;
            case (wr_addr)
                `SPTC_OFS_CTRL:  ctrl_q            <= ctrl_merged[3:0];
                `SPTC_OFS_TOTAL: total_pulse_count <= merge(total_pulse_count, wr_data, wr_strb);
                `SPTC_OFS_FREQ:  freq_cfg_q        <= merge(freq_cfg_q, wr_data, wr_strb);
                `SPTC_OFS_RATE:  rate_cfg_q        <= merge(rate_cfg_q, wr_data, wr_strb);
                `SPTC_OFS_JOG:   jog_cfg_q         <= merge(jog_cfg_q, wr_data, wr_strb);
                default:         ctrl_q            <= ctrl_q;
            endcase
        end
        if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
        end
    end
end

// ============================================================
// AXI4-Lite read channel
reg [31:0] rd_word;
reg        rd_ok;
always @* begin
    rd_ok   = 1'b1;
    rd_word = `SPTC_RST_WORD;
    case (s_axi_araddr)
        `SPTC_OFS_CTRL:   rd_word = {28'h000_0000, ctrl_q};
        `SPTC_OFS_TOTAL:  rd_word = total_pulse_count;
        `SPTC_OFS_FREQ:   rd_word = freq_cfg_q;
        `SPTC_OFS_RATE:   rd_word = rate_cfg_q;
        `SPTC_OFS_JOG:    rd_word = jog_cfg_q;
        `SPTC_OFS_STATUS: rd_word = {22'h00_0000, state_q, abort_q, manual_q,
                                     pulse_out, job_active_output};
        `SPTC_OFS_PULSES: rd_word = cnt_q;
        default:          rd_ok   = 1'b0;
    endcase
end

always @(posedge mclk) begin
    if (rst) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b0;
        s_axi_rdata   <= `SPTC_RST_WORD;
        s_axi_rresp   <= `SPTC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_ok ? `SPTC_RESP_OKAY : `SPTC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
    end
end

endmodule // sptc_top
`default_nettype wire

// file: verilog/sptc_map.vh
// Purpose: Constants of the stepper pulse-train control block
// Assumes: 200 MHz mclk, AXI4-Lite register access
// Notes:   Offsets are byte addresses
`ifndef SPTC_MAP_VH
`define SPTC_MAP_VH
// ============================================================
// Register offsets
`define SPTC_OFS_CTRL    8'h00
`define SPTC_OFS_TOTAL   8'h04
`define SPTC_OFS_FREQ    8'h08
`define SPTC_OFS_RATE    8'h0c
`define SPTC_OFS_JOG     8'h10
`define SPTC_OFS_STATUS  8'h14
`define SPTC_OFS_PULSES  8'h18
// ============================================================
// Control field positions
`define SPTC_CTRL_EN     0
`define SPTC_CTRL_START  1
`define SPTC_CTRL_BRAKE  2
`define SPTC_CTRL_JOG    3
// ============================================================
// Reset values
`define SPTC_RST_CTRL    4'h0
`define SPTC_RST_WORD    32'h0000_0000
// ============================================================
// Timing
`define SPTC_CLK_KHZ     200000
`define SPTC_JOG_HOLD_MS 500
`define SPTC_HALF_PERIOD 40'h17_4876_e800
`define SPTC_MHZ_PER_HZ  1000
`define SPTC_DIV_STEPS   6'h20
// ============================================================
// Bus responses
`define SPTC_RESP_OKAY   2'b00
`define SPTC_RESP_SLVERR 2'b10
`endif

// file: tb/sptc_stage_model.sv
// Purpose: Motor stage input model, counts and times step pulses
// Assumes: Pulse sampled on mclk, opto input has no output
// Notes:   A pulse is counted when it falls, like the design
`timescale 1ns/1ps
`default_nettype none
module sptc_stage_model (
    // Clock and step input
    input wire logic mclk,
    input wire logic pulse_out
);
    int n_pulses = 0;
    int hi_len   = 0;
    int hi_w[0:63];
    // ==========================================
    // Pulse capture
    always @(posedge mclk) begin
        if (pulse_out) begin
            hi_len <= hi_len + 1;
        end else if (hi_len != 0) begin
            hi_w[n_pulses % 64] <= hi_len;
            n_pulses            <= n_pulses + 1;
            hi_len              <= 0;
        end
    end
endmodule // sptc_stage_model
`default_nettype wire

// file: tb/sptc_top_chk.sv
// Purpose: Port-level checker for sptc_top
// Assumes: One clock, synchronous active-high reset
// Notes:   Attached by bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module sptc_top_chk #(
    parameter [31:0] JOG_HOLD_CYCLES = 32'd200
) (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rst,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Motor stage
    input wire logic        pulse_out,
    input wire logic        job_active_output
);
    default clocking dcb @(posedge mclk); endclocking
    default disable iff (rst);
    // ==========================================
    // Register bus
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write response late");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read response late");
    bresp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00 || s_axi_bresp == 2'b10)
        else $error("write response code unknown");
    // ==========================================
    // Motor stage
    pulse_in_job_a: assert property (pulse_out |-> job_active_output)
        else $error("pulse outside a job");
    high_width_a: assert property ($rose(pulse_out) |=> pulse_out [*8])
        else $error("pulse high time too short");
    low_width_a: assert property ($fell(pulse_out) && job_active_output |=> !pulse_out [*8])
        else $error("pulse low time too short");
    job_end_a: assert property ($fell(job_active_output) |-> !pulse_out ##1 !pulse_out [*8])
        else $error("pulse around job end");
    cover property ($rose(pulse_out));
    cover property ($fell(job_active_output));
    cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule // sptc_top_chk
bind sptc_top sptc_top_chk #(.JOG_HOLD_CYCLES(JOG_HOLD_CYCLES)) u_chk (.*);
`default_nettype wire

// file: tb/sptc_top_bench.sv
// Purpose: Self-checking bench for sptc_top
// Assumes: Stage model counts pulses at their falling edge
// Notes:   Fast step rates keep each pulse near 3200 cycles
`timescale 1ns/1ps
`default_nettype none
`include "sptc_map.vh"
module sptc_top_bench;
    logic        mclk = 1'b0;
    logic        rst;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pulse_out, job_active_output;
    int          num_errors = 0;
    int          checks = 0;
    int          b = 0;

    sptc_top #(.JOG_HOLD_CYCLES(32'd200)) u_dut (.*);
    sptc_stage_model u_stage (.*);

    always #2.5 mclk = ~mclk;
    // ==========================================
    // Checking and closing
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic hang(input string what);
        chk(what, 32'h1, 32'h0);
        close_out;
    endtask
    function automatic int w(input int k);
        return u_stage.hi_w[(b + k) % 64];
    endfunction
    // ==========================================
    // Register bus master
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int i;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (i == 100) hang("write answer");
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int i;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (i == 100) hang("read answer");
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        axi_write(a, d, resp);
        chk("write response", {30'h0, e}, {30'h0, resp});
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        axi_read(a, rd, resp);
        chk("read response", {30'h0, er}, {30'h0, resp});
        chk("read data", e, rd);
    endtask
    task automatic ctrl(input logic [3:0] v);
        wr(`SPTC_OFS_CTRL, {28'h0, v}, `SPTC_RESP_OKAY);
    endtask
    // ==========================================
    // Bounded waits
    task automatic wait_pulses(input int n);
        int i;
        for (i = 0; i < 4000 * n && u_stage.n_pulses < b + n; i++) @(posedge mclk);
        if (i == 4000 * n) hang("pulse count");
    endtask
    task automatic wait_idle;
        int i;
        for (i = 0; i < 30000 && job_active_output !== 1'b0; i++) @(posedge mclk);
        if (i == 30000) hang("job end");
        @(posedge mclk);
    endtask
    task automatic idle_chk(input int cyc);
        repeat (cyc) @(posedge mclk);
        chk("job active", 32'h0, {31'h0, job_active_output});
    endtask
    // ==========================================
    // Sequence
    initial begin
        rst = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        for (int k = 0; k < 7; k++)
            if (k != 5) rdchk(8'(4 * k), `SPTC_RST_WORD, `SPTC_RESP_OKAY);
        rdchk(8'h1c, 32'h0, `SPTC_RESP_SLVERR);
        rdchk(8'h02, 32'h0, `SPTC_RESP_SLVERR);
        wr(8'h1c, 32'h1, `SPTC_RESP_SLVERR);
        wr(`SPTC_OFS_STATUS, 32'h1, `SPTC_RESP_SLVERR);
        wr(`SPTC_OFS_CTRL, 32'hffff_fff0, `SPTC_RESP_OKAY);
        rdchk(`SPTC_OFS_CTRL, 32'h0, `SPTC_RESP_OKAY);
        // Flat job at one rate, second start edge mid-job
        wr(`SPTC_OFS_FREQ, 32'hf424_f424, `SPTC_RESP_OKAY);
        wr(`SPTC_OFS_RATE, 32'hf424_f424, `SPTC_RESP_OKAY);
        wr(`SPTC_OFS_TOTAL, 32'h3, `SPTC_RESP_OKAY);
        b = u_stage.n_pulses;
        ctrl(4'h1);
        ctrl(4'h3);
        repeat (3) @(posedge mclk);
        chk("job active", 32'h1, {31'h0, job_active_output});
        wait_pulses(1);
        ctrl(4'h1);
        ctrl(4'h3);
        wait_idle;
        chk("pulse count", 32'd3, 32'(u_stage.n_pulses - b));
        chk("high time", 32'd1600, 32'(w(0)));
        idle_chk(100);
        // Two-pulse ramps each way
        wr(`SPTC_OFS_FREQ, 32'hf424_f3a7, `SPTC_RESP_OKAY);
        wr(`SPTC_OFS_TOTAL, 32'h6, `SPTC_RESP_OKAY);
        b = u_stage.n_pulses;
        ctrl(4'h1);
        ctrl(4'h3);
        wait_pulses(1);
        wait_idle;
        chk("pulse count", 32'd6, 32'(u_stage.n_pulses - b));
        chk("ramp shape", 32'h3f, {26'h0, w(0) > 1601, w(1) > 1600, w(2) < 1602,
                                   w(3) < 1602, w(4) > 1600, w(5) > 1601});
        // Abort into braking, start edge while braking
        wr(`SPTC_OFS_TOTAL, 32'd100, `SPTC_RESP_OKAY);
        b = u_stage.n_pulses;
        ctrl(4'h1);
        ctrl(4'h3);
        wait_pulses(3);
        ctrl(4'h7);
        chk("job active", 32'h1, {31'h0, job_active_output});
        ctrl(4'h5);
        ctrl(4'h7);
        wait_idle;
        chk("abort stop", 32'h1, {31'h0, u_stage.n_pulses - b < 8});
        idle_chk(100);
        ctrl(4'h5);
        ctrl(4'h7);
        idle_chk(100);
        ctrl(4'h0);
        ctrl(4'ha);
        idle_chk(100);
        // Disable in the middle of a pulse
        b = u_stage.n_pulses;
        ctrl(4'h1);
        ctrl(4'h3);
        wait_pulses(1);
        repeat (1700) @(posedge mclk);
        chk("pulse high", 32'h1, {31'h0, pulse_out});
        ctrl(4'h2);
        repeat (2) @(posedge mclk);
        chk("stopped", 32'h0, {30'h0, pulse_out, job_active_output});
        ctrl(4'h1);
        idle_chk(100);
        // Short jog with brake edge, then manual jog
        wr(`SPTC_OFS_FREQ, 32'hf424_f424, `SPTC_RESP_OKAY);
        wr(`SPTC_OFS_JOG, 32'hf424_0003, `SPTC_RESP_OKAY);
        b = u_stage.n_pulses;
        ctrl(4'h9);
        ctrl(4'hd);
        ctrl(4'h5);
        wait_pulses(1);
        wait_idle;
        chk("jog steps", 32'd3, 32'(u_stage.n_pulses - b));
        b = u_stage.n_pulses;
        ctrl(4'h1);
        ctrl(4'h9);
        wait_pulses(4);
        chk("jog high time", 32'd1600, 32'(w(3)));
        ctrl(4'h1);
        repeat (2) @(posedge mclk);
        chk("jog released", 32'h0, {30'h0, pulse_out, job_active_output});
        close_out;
    end
endmodule // sptc_top_bench
`default_nettype wire
